/* hdl/mpcd_decoder.sv */
// Command decoder and executor for sensor feed, jump, home, message and comment.
// Functional notes
// - Sensor feed code selects direction and level
// - On stop: full brake, both sides, hold
// - Second operand: single input or mask
// - Sensor feed from program or terminal
// - Plain jump to line or program
// - Control word selects call and program target
// - Control bits pick comparison relation
// - Low byte is target; F,E,B reserved
// - Compare two variables, jump when true
// - Home to stroke end, zero position
// - Home operand picks direction
// - Message up to 60 characters, backslash reserved
// - Keypad data stored float or integer
// - Variable zero: display only; empty clears
// - One 1024 character text store
// - Show text on LCD, capture keypad
module mpcd_decoder (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_from_terminal,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [15:0] cmd_arg1,
  input  wire logic [15:0] cmd_arg2,
  input  wire logic [15:0] cmd_arg3,
  input  wire logic [9:0]  cmd_text_base,
  input  wire logic [5:0]  cmd_text_len,
  output logic             cmd_ready,
  output logic             cmd_done,
  // Text loading
  input  wire logic        text_wr_en,
  input  wire logic [9:0]  text_wr_addr,
  input  wire logic [7:0]  text_wr_data,
  // Program flow
  output logic             jump_taken,
  output logic             jump_is_call,
  output logic             jump_to_prog,
  output logic      [7:0]  jump_target,
  // Variable store
  output logic      [5:0]  var_addr,
  input  wire logic [31:0] var_rdata,
  output logic             var_wr,
  output logic             var_wr_float,
  output logic      [31:0] var_wdata,
  // Motion
  input  wire logic [6:0]  dig_in,
  input  wire logic        end_of_stroke,
  input  wire logic [7:0]  hold_torque,
  output logic             move_fwd,
  output logic             move_back,
  output logic             both_sides,
  output logic      [7:0]  brake_level,
  output logic             pos_zero,
  // LCD and keypad
  output logic             lcd_clear,
  output logic             lcd_char_valid,
  output logic      [7:0]  lcd_char,
  input  wire logic        key_valid,
  input  wire logic [31:0] key_value
);
  mpcd_pkg::mpcd_state_t state_q;
  logic [6:0]  in_s1_q, in_s2_q;
  logic        eos_s1_q, eos_s2_q;
  logic        lvl_q, fwd_q, single_q, home_tb_q;
  logic [6:0]  mask_q;
  logic [15:0] a1_q, a2_q, a3_q;
  logic [31:0] v1_q;
  logic [11:0] tmr_q;
  logic [9:0]  rd_addr_q;
  logic [5:0]  left_q;
  logic        rd_pend_q;
  logic [7:0]  rd_data;
  logic        hit;

  function automatic logic cmp_rel(input logic [2:0] code, input logic [31:0] a,
                                   input logic [31:0] b);
    // Unlisted codes behave as no condition.
    // bad codes none
    unique case (code)
      mpcd_pkg::CMP_GT: cmp_rel = $signed(a) > $signed(b);
      mpcd_pkg::CMP_GE: cmp_rel = $signed(a) >= $signed(b);
      mpcd_pkg::CMP_EQ: cmp_rel = a == b;
      mpcd_pkg::CMP_LT: cmp_rel = $signed(a) < $signed(b);
      mpcd_pkg::CMP_LE: cmp_rel = $signed(a) <= $signed(b);
      mpcd_pkg::CMP_NE: cmp_rel = a != b;
      default:          cmp_rel = 1'b1;
    endcase
  endfunction : cmp_rel

  // Pins are asynchronous to mclk.
  always_ff @(posedge mclk) begin
    in_s1_q  <= dig_in;
    in_s2_q  <= in_s1_q;
    eos_s1_q <= end_of_stroke;
    eos_s2_q <= eos_s1_q;
  end

  always_comb begin
    if (single_q) begin
      hit = in_s2_q[mask_q[2:0] - 3'h1] == lvl_q;
    end else begin
      hit = ((lvl_q ? in_s2_q : ~in_s2_q) & mask_q) == mask_q;
    end
  end

  mpcd_text_mem u_text (
    .mclk    (mclk),
    .wr_en   (text_wr_en),
    .wr_addr (text_wr_addr),
    .wr_data (text_wr_data),
    .rd_addr (rd_addr_q),
    .rd_data (rd_data)
  );

  assign cmd_ready = (state_q == mpcd_pkg::ST_IDLE);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= mpcd_pkg::ST_IDLE;
      {lvl_q, fwd_q, single_q, home_tb_q} <= 4'h0;
      mask_q <= 7'h00;
      a1_q <= 16'h0000;
      a2_q <= 16'h0000;
      a3_q <= 16'h0000;
      v1_q <= 32'h00000000;
      tmr_q <= 12'h000;
      rd_addr_q <= 10'h000;
      left_q <= 6'h00;
      rd_pend_q <= 1'b0;
      cmd_done <= 1'b0;
      jump_taken <= 1'b0;
      jump_is_call <= 1'b0;
      jump_to_prog <= 1'b0;
      jump_target <= 8'h00;
      var_addr <= 6'h00;
      var_wr <= 1'b0;
      var_wr_float <= 1'b0;
      var_wdata <= 32'h00000000;
      move_fwd <= 1'b0;
      move_back <= 1'b0;
      both_sides <= 1'b0;
      brake_level <= 8'h00;
      pos_zero <= 1'b0;
      lcd_clear <= 1'b0;
      lcd_char_valid <= 1'b0;
      lcd_char <= 8'h00;
    end else begin
      cmd_done <= 1'b0;
      jump_taken <= 1'b0;
      var_wr <= 1'b0;
      pos_zero <= 1'b0;
      lcd_clear <= 1'b0;
      lcd_char_valid <= 1'b0;
      unique case (state_q)
        mpcd_pkg::ST_IDLE: begin
          if (cmd_valid) begin
            a1_q <= cmd_arg1;
            a2_q <= cmd_arg2;
            a3_q <= cmd_arg3;
            unique case (cmd_op)
              mpcd_pkg::OP_SENSOR_FEED: begin
                if (cmd_arg1 == mpcd_pkg::SF_BACK_LOW || cmd_arg1 == mpcd_pkg::SF_BACK_HIGH ||
                    cmd_arg1 == mpcd_pkg::SF_FWD_LOW || cmd_arg1 == mpcd_pkg::SF_FWD_HIGH) begin
                  lvl_q     <= cmd_arg1[0];
                  fwd_q     <= cmd_arg1[12];
                  move_fwd  <= cmd_arg1[12];
                  move_back <= ~cmd_arg1[12];
                  brake_level <= 8'h00;
                  both_sides <= 1'b0;
                  single_q  <= cmd_arg2[15:4] == 12'h000 && cmd_arg2[3:0] != 4'h0 &&
                               cmd_arg2[3:0] <= mpcd_pkg::SF_SINGLE_MAX;
                  mask_q    <= cmd_arg2[6:0] & mpcd_pkg::SF_MASK_MAX;
                  state_q   <= mpcd_pkg::ST_FEED;
                end else begin
                  state_q <= mpcd_pkg::ST_DONE;
                end
              end
              mpcd_pkg::OP_JUMP: begin
                if (cmd_arg1[15:8] == mpcd_pkg::VAR_FLOAT_HI) begin
                  var_addr <= cmd_arg1[5:0];
                  state_q  <= mpcd_pkg::ST_JUMP_RD;
                end else begin
                  jump_taken   <= (cmd_arg1 <= mpcd_pkg::JMP_LINE_MAX) ||
                                  (cmd_arg1 >= mpcd_pkg::JMP_PROG_MIN &&
                                   cmd_arg1 <= mpcd_pkg::JMP_PROG_MAX);
                  jump_is_call <= 1'b0;
                  jump_to_prog <= cmd_arg1[mpcd_pkg::CW_PROG_BIT];
                  jump_target  <= cmd_arg1[7:0];
                  state_q      <= mpcd_pkg::ST_DONE;
                end
              end
              mpcd_pkg::OP_HOME: begin
                home_tb_q <= cmd_arg1[0];
                move_fwd  <= cmd_arg1[0];
                move_back <= ~cmd_arg1[0];
                state_q   <= mpcd_pkg::ST_HOME;
              end
              mpcd_pkg::OP_MESSAGE: begin
                rd_addr_q <= cmd_text_base;
                left_q <= (cmd_text_len > mpcd_pkg::MSG_LEN_MAX) ? mpcd_pkg::MSG_LEN_MAX
                                                                  : cmd_text_len;
                lcd_clear <= (cmd_text_len == 6'h00);
                rd_pend_q <= 1'b0;
                state_q   <= mpcd_pkg::ST_MSG;
              end
              default: state_q <= mpcd_pkg::ST_DONE;
            endcase
          end
        end
        mpcd_pkg::ST_FEED: begin
          if (hit) begin
            move_fwd    <= 1'b0;
            move_back   <= 1'b0;
            brake_level <= mpcd_pkg::BRAKE_FULL;
            tmr_q       <= 12'(mpcd_pkg::CLAMP_CYC - 1);
            state_q     <= mpcd_pkg::ST_CLAMP;
          end
        end
        mpcd_pkg::ST_CLAMP: begin
          if (tmr_q == 12'h000) begin
            both_sides <= 1'b1;
            tmr_q      <= 12'(mpcd_pkg::PRESS_CYC - 1);
            state_q    <= mpcd_pkg::ST_PRESS;
          end else begin
            tmr_q <= tmr_q - 12'h001;
          end
        end
        mpcd_pkg::ST_PRESS: begin
          if (tmr_q == 12'h000) begin
            brake_level <= hold_torque;
            state_q     <= mpcd_pkg::ST_DONE;
          end else begin
            tmr_q <= tmr_q - 12'h001;
          end
        end
        mpcd_pkg::ST_HOME: begin
          if (eos_s2_q) begin
            move_fwd  <= 1'b0;
            move_back <= 1'b0;
            pos_zero  <= 1'b1;
            state_q   <= mpcd_pkg::ST_DONE;
          end
        end
        mpcd_pkg::ST_JUMP_RD: begin
          v1_q     <= var_rdata;
          var_addr <= a3_q[5:0];
          state_q  <= mpcd_pkg::ST_JUMP_CMP;
        end
        mpcd_pkg::ST_JUMP_CMP: begin
          jump_taken   <= cmp_rel(a2_q[mpcd_pkg::CW_CMP_LSB +: 3], v1_q, var_rdata);
          jump_is_call <= a2_q[mpcd_pkg::CW_CALL_BIT];
          jump_to_prog <= a2_q[mpcd_pkg::CW_PROG_BIT];
          jump_target  <= a2_q[mpcd_pkg::CW_TGT_LSB +: 8];
          state_q      <= mpcd_pkg::ST_DONE;
        end
        mpcd_pkg::ST_MSG: begin
          if (rd_pend_q) begin
            if (rd_data != mpcd_pkg::CHAR_DELIM) begin
              lcd_char_valid <= 1'b1;
              lcd_char       <= rd_data;
            end
          end
          // The address runs one read ahead of the display so no byte is shown twice.
          if (left_q != 6'h00) begin
            rd_pend_q <= 1'b1;
            rd_addr_q <= rd_addr_q + 10'h001;
            left_q    <= left_q - 6'h01;
          end else begin
            rd_pend_q <= 1'b0;
            state_q <= (a2_q == 16'h0000) ? mpcd_pkg::ST_DONE : mpcd_pkg::ST_KEY;
          end
        end
        mpcd_pkg::ST_KEY: begin
          if (key_valid) begin
            var_addr     <= a2_q[5:0];
            var_wdata    <= key_value;
            var_wr_float <= a2_q[15:8] == mpcd_pkg::VAR_FLOAT_HI;
            var_wr       <= 1'b1;
            state_q      <= mpcd_pkg::ST_DONE;
          end
        end
        mpcd_pkg::ST_DONE: begin
          cmd_done <= 1'b1;
          state_q  <= mpcd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Full brake must precede both-side pressure.
  a_brake_before_air: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(both_sides) |-> brake_level == mpcd_pkg::BRAKE_FULL)
    else $error("pressure applied without full brake");
  a_home_zero_stop: assert property (@(posedge mclk) disable iff (!reset_n)
    pos_zero |-> !move_fwd && !move_back ##1 cmd_done)
    else $error("home zeroed while moving");
  a_feed_stops_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == mpcd_pkg::ST_FEED && hit |=> !move_fwd && !move_back)
    else $error("feed kept moving after hit");
  a_key_store_var: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == mpcd_pkg::ST_KEY && key_valid |=> var_wr && var_wdata == $past(key_value))
    else $error("keypad value not stored");
  a_cond_jump_result: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == mpcd_pkg::ST_JUMP_CMP && a2_q[10:8] == mpcd_pkg::CMP_EQ
    |=> jump_taken == ($past(v1_q) == $past(var_rdata)))
    else $error("equal compare wrong");
  a_jump_call_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == mpcd_pkg::ST_JUMP_CMP |=> jump_is_call == $past(a2_q[13]))
    else $error("call bit mismatch");
  a_comment_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_ready && cmd_valid && cmd_op == mpcd_pkg::OP_COMMENT
    |=> !jump_taken && !var_wr ##1 cmd_done)
    else $error("comment had an effect");
  a_msg_no_delim: assert property (@(posedge mclk) disable iff (!reset_n)
    lcd_char_valid |-> lcd_char != mpcd_pkg::CHAR_DELIM)
    else $error("delimiter shown on display");
endmodule : mpcd_decoder

/* hdl/mpcd_pkg.sv */
// Package of constants and types for the motion program command decoder.
package mpcd_pkg;
  // Command opcodes presented on the command port.
  localparam logic [2:0] OP_SENSOR_FEED = 3'h1;
  localparam logic [2:0] OP_JUMP        = 3'h2;
  localparam logic [2:0] OP_HOME        = 3'h3;
  localparam logic [2:0] OP_MESSAGE     = 3'h4;
  localparam logic [2:0] OP_COMMENT     = 3'h5;
  // Sensor feed first operand codes and second operand limits.
  localparam logic [15:0] SF_BACK_LOW  = 16'h0000;
  localparam logic [15:0] SF_BACK_HIGH = 16'h0001;
  localparam logic [15:0] SF_FWD_LOW   = 16'h1000;
  localparam logic [15:0] SF_FWD_HIGH  = 16'h1001;
  localparam logic [6:0]  SF_MASK_MAX  = 7'h7F;
  localparam logic [3:0]  SF_SINGLE_MAX = 4'h7;
  // Jump targets and control word fields.
  localparam logic [15:0] JMP_LINE_MAX = 16'h00FF;
  localparam logic [15:0] JMP_PROG_MIN = 16'h1000;
  localparam logic [15:0] JMP_PROG_MAX = 16'h1009;
  localparam int CW_CALL_BIT = 13;
  localparam int CW_PROG_BIT = 12;
  localparam int CW_CMP_LSB  = 8;
  localparam int CW_TGT_LSB  = 0;
  localparam logic [2:0] CMP_NONE = 3'h0;
  localparam logic [2:0] CMP_GT   = 3'h1;
  localparam logic [2:0] CMP_GE   = 3'h2;
  localparam logic [2:0] CMP_EQ   = 3'h3;
  localparam logic [2:0] CMP_LT   = 3'h4;
  localparam logic [2:0] CMP_LE   = 3'h5;
  localparam logic [2:0] CMP_NE   = 3'h6;
  // Variable addresses.
  localparam logic [7:0] VAR_FLOAT_HI = 8'h80;
  localparam logic [7:0] VAR_INT_HI   = 8'hA0;
  localparam logic [7:0] VAR_IDX_MAX  = 8'h3F;
  localparam int VAR_COUNT = 64;
  // Text store and message limits.
  localparam int TEXT_DEPTH = 1024;
  localparam int TEXT_AW    = 10;
  localparam logic [5:0] MSG_LEN_MAX = 6'h3C;
  localparam logic [7:0] CHAR_DELIM  = 8'h5C;
  // Brake current levels.
  localparam logic [7:0] BRAKE_FULL = 8'hFF;
  // Settling times after a sensor stop, in microseconds.
  localparam int CLK_MHZ       = 10;
  localparam int CLAMP_US      = 100;
  localparam int CLAMP_CYC     = CLAMP_US * CLK_MHZ;
  localparam int PRESS_US      = 100;
  localparam int PRESS_CYC     = PRESS_US * CLK_MHZ;
  localparam int TIMER_W       = 12;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FEED, ST_CLAMP, ST_PRESS, ST_HOME, ST_JUMP_RD, ST_JUMP_CMP,
    ST_MSG, ST_KEY, ST_DONE
  } mpcd_state_t;
endpackage : mpcd_pkg

/* hdl/mpcd_text_mem.sv */
// Shared message and comment text store with registered read data.
module mpcd_text_mem (
  // Clock
  input  wire logic        mclk,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [9:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // Read port
  input  wire logic [9:0]  rd_addr,
  output logic      [7:0]  rd_data
);
  logic [7:0] mem [0:mpcd_pkg::TEXT_DEPTH-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : mpcd_text_mem

/* tb/mpcd_decoder_tb.sv */
// Self-checking testbench for the motion program command decoder.
module mpcd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_from_terminal = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [15:0] cmd_arg1 = 16'h0000;
  logic [15:0] cmd_arg2 = 16'h0000;
  logic [15:0] cmd_arg3 = 16'h0000;
  logic [9:0]  cmd_text_base = 10'h000;
  logic [5:0]  cmd_text_len = 6'h00;
  logic        text_wr_en = 1'b0;
  logic [9:0]  text_wr_addr = 10'h000;
  logic [7:0]  text_wr_data = 8'h00;
  logic [6:0]  dig_in = 7'h00;
  logic        end_of_stroke = 1'b0;
  logic [7:0]  hold_torque = 8'h2A;
  logic        key_press = 1'b0;
  logic [31:0] key_data = 32'h0000_0000;
  logic        cmd_ready, cmd_done, jump_taken, jump_is_call, jump_to_prog, var_wr;
  logic        var_wr_float, move_fwd, move_back, both_sides, pos_zero, key_valid;
  logic        lcd_clear, lcd_char_valid;
  logic [7:0]  jump_target, brake_level, lcd_char;
  logic [5:0]  var_addr;
  logic [31:0] var_rdata, var_wdata, key_value;
  int          n_mismatch, comparisons, n_jump, n_zero, n_clear, n_wr, cyc;
  logic        j_call, j_prog, w_float;
  logic [7:0]  j_tgt;
  logic [7:0]  lcd_q[$];

  always #50 mclk = ~mclk;

  mpcd_decoder dut (.mclk, .reset_n, .cmd_valid, .cmd_from_terminal, .cmd_op, .cmd_arg1,
    .cmd_arg2, .cmd_arg3, .cmd_text_base, .cmd_text_len, .cmd_ready, .cmd_done, .text_wr_en,
    .text_wr_addr, .text_wr_data, .jump_taken, .jump_is_call, .jump_to_prog, .jump_target,
    .var_addr, .var_rdata, .var_wr, .var_wr_float, .var_wdata, .dig_in, .end_of_stroke,
    .hold_torque, .move_fwd, .move_back, .both_sides, .brake_level, .pos_zero, .lcd_clear,
    .lcd_char_valid, .lcd_char, .key_valid, .key_value);

  mpcd_partner model (.mclk, .var_addr, .var_rdata, .var_wr, .var_wdata, .key_press,
    .key_data, .key_valid, .key_value);

  // Pulses are caught at the falling edge, where registered outputs have settled.
  always @(negedge mclk) begin
    if (jump_taken === 1'b1) begin
      n_jump++;
      {j_call, j_prog, j_tgt} = {jump_is_call, jump_to_prog, jump_target};
    end
    if (pos_zero === 1'b1) n_zero++;
    if (lcd_clear === 1'b1) n_clear++;
    if (lcd_char_valid === 1'b1) lcd_q.push_back(lcd_char);
    if (var_wr === 1'b1) begin
      n_wr++;
      w_float = var_wr_float;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [2:0] op, input logic [15:0] a1, a2, a3);
    @(negedge mclk);
    {n_jump, n_zero, n_clear, n_wr} = '0;
    lcd_q.delete();
    {cmd_op, cmd_arg1, cmd_arg2, cmd_arg3} = {op, a1, a2, a3};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : send

  // Counts cycles from the taking cycle to cmd_done, bounded; a missing done is a mismatch.
  task automatic wait_done();
    cyc = 1;
    do begin
      @(negedge mclk);
      cyc++;
    end while (cmd_done !== 1'b1 && cyc < 3000);
    chk(cmd_done, 1'b1);
  endtask : wait_done

  task automatic wait_for(input logic [31:0] val, ref logic [7:0] sig, input int lim);
    cyc = 0;
    while (sig !== val[7:0] && cyc < lim) begin
      @(negedge mclk);
      cyc++;
    end
  endtask : wait_for

  task automatic t_plain();
    logic [15:0] tg [6] = '{16'h0064, 16'h1005, 16'h0100, 16'h00FF, 16'h1009, 16'h100A};
    for (int i = 0; i < 6; i++) begin
      send(mpcd_pkg::OP_JUMP, tg[i], 16'h0000, 16'h0000);
      wait_done();
      chk(cyc, 2);
      chk(n_jump, (i == 2 || i == 5) ? 0 : 1);
      if (n_jump == 1) chk({j_prog, j_tgt}, {tg[i][12], tg[i][7:0]});
    end
  endtask : t_plain

  task automatic t_cond();
    logic [7:0]  taken = 8'hC7;
    logic [15:0] cw;
    model.vars[0] = 32'h0000_0005;
    model.vars[1] = 32'hFFFF_FFFF;
    for (int c = 0; c < 8; c++) begin
      cw = {2'b00, c[0], c[1], 1'b0, c[2:0], 8'h05};
      if (c == 7) cw = cw | 16'hC800;
      send(mpcd_pkg::OP_JUMP, 16'h8000, cw, 16'h8001);
      wait_done();
      chk(cyc, 4);
      chk(n_jump, taken[c]);
      if (n_jump == 1) chk({j_call, j_prog, j_tgt}, {c[0], c[1], 8'h05});
    end
  endtask : t_cond

  task automatic t_home(input logic dir);
    send(mpcd_pkg::OP_HOME, {15'h0000, dir}, 16'h0000, 16'h0000);
    repeat (3) @(negedge mclk);
    chk({move_fwd, move_back}, {dir, ~dir});
    end_of_stroke = 1'b1;
    wait_done();
    chk(n_zero, 1);
    end_of_stroke = 1'b0;
  endtask : t_home

  task automatic t_feed(input logic [15:0] code, a2, input logic [6:0] idle, hit);
    dig_in = idle;
    send(mpcd_pkg::OP_SENSOR_FEED, code, a2, 16'h0000);
    repeat (3) @(negedge mclk);
    chk({move_fwd, move_back}, {code[12], ~code[12]});
    // the stop level stays asserted until the command completes.
    dig_in = hit;
    wait_for(mpcd_pkg::BRAKE_FULL, brake_level, 10);
    chk({brake_level, move_fwd, move_back, both_sides}, {mpcd_pkg::BRAKE_FULL, 3'b000});
    cyc = 0;
    while (both_sides !== 1'b1 && cyc < 1100) begin
      @(negedge mclk);
      cyc++;
    end
    chk(cyc > mpcd_pkg::CLAMP_CYC - 3 && cyc < mpcd_pkg::CLAMP_CYC + 3, 1);
    wait_for(hold_torque, brake_level, 1100);
    chk(cyc > mpcd_pkg::PRESS_CYC - 3 && cyc < mpcd_pkg::PRESS_CYC + 3, 1);
    wait_done();
    chk({brake_level, both_sides}, {hold_torque, 1'b1});
  endtask : t_feed

  task automatic t_msg(input logic [15:0] vr, input logic [5:0] len);
    logic [7:0] txt [4] = '{8'h48, 8'h69, mpcd_pkg::CHAR_DELIM, 8'h21};
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {text_wr_en, text_wr_addr, text_wr_data} = {1'b1, 10'(1020 + i), txt[i]};
    end
    @(negedge mclk);
    text_wr_en = 1'b0;
    {cmd_text_base, cmd_text_len} = {10'd1020, len};
    send(mpcd_pkg::OP_MESSAGE, 16'h0000, vr, 16'h0000);
    for (int i = 0; i < 200 && lcd_q.size() < int'(len) - 1; i++) @(negedge mclk);
    if (len != 0) begin
      chk({lcd_q[0], lcd_q[1], lcd_q[2]}, 24'h486921);
      key_data = 32'h1234_5678;
      key_press = 1'b1;
      @(negedge mclk);
      key_press = 1'b0;
    end
    wait_done();
    chk(n_wr, len != 0);
    chk(n_clear, len == 0);
    if (len != 0) chk(w_float, vr[15:12] == 4'h8);
    if (len != 0) chk(model.vars[vr[5:0]], 32'h1234_5678);
  endtask : t_msg

  task automatic t_comment();
    for (int i = 0; i < 2; i++) begin
      @(negedge mclk);
      {text_wr_en, text_wr_addr} = {1'b1, 10'(i)};
      text_wr_data = (i == 0) ? mpcd_pkg::CHAR_DELIM : 8'h30;
    end
    @(negedge mclk);
    text_wr_en = 1'b0;
    send(mpcd_pkg::OP_COMMENT, 16'h1001, 16'h0001, 16'h0000);
    wait_done();
    chk(cyc, 2);
    chk(n_jump, 0);
    chk({move_fwd, move_back, brake_level}, {2'b00, hold_torque});
  endtask : t_comment

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial begin
    #(100 * 20000);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    chk(cmd_ready, 1);
    t_plain();
    t_cond();
    t_home(1'b0);
    t_home(1'b1);
    t_feed(mpcd_pkg::SF_FWD_HIGH, 16'h0007, 7'h00, 7'h40);
    cmd_from_terminal = 1'b1;
    t_feed(mpcd_pkg::SF_BACK_LOW, 16'h0037, 7'h7F, 7'h48);
    cmd_from_terminal = 1'b0;
    t_comment();
    t_msg(16'hA002, 6'h04);
    t_msg(16'h8001, 6'h04);
    t_msg(16'h0000, 6'h00);
    wrap_up();
  end
endmodule : mpcd_decoder_tb

/* tb/mpcd_partner.sv */
// Partner model: variable store and keypad facing the decoder.
module mpcd_partner (
  // Clock
  input  wire logic        mclk,
  // Variable store
  input  wire logic [5:0]  var_addr,
  output logic      [31:0] var_rdata,
  input  wire logic        var_wr,
  input  wire logic [31:0] var_wdata,
  // Keypad
  input  wire logic        key_press,
  input  wire logic [31:0] key_data,
  output logic             key_valid,
  output logic      [31:0] key_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] vars [64];
  logic        press_q = 1'b0;
  initial key_valid = 1'b0;
  initial key_value = 32'h0000_0000;
  assign var_rdata = vars[var_addr];
  always @(posedge mclk) begin
    if (var_wr === 1'b1) vars[var_addr] <= var_wdata;
  end
  // one key pulse per press; value is garbage between presses.
  // Sampling on the rising edge keeps clear of the bench's falling-edge stimulus.
  always @(posedge mclk) begin
    key_valid <= key_press & ~press_q;
    press_q   <= key_press;
    key_value <= (key_press & ~press_q) ? key_data : ~key_value;
  end
endmodule : mpcd_partner
